// File: rtl/emf_forward_decision.sv
// Forwarding decision from the external address match code and VLAN maps.
// Assumes frame_start arrives on sys_clk at least two cycles after the
// external code pins are stable, and frame_queued marks the end of queueing.
// Functional notes
// - Single-port codes 0-9 select port, 15 broadcasts
// - Mode and single flag high: use internal match
// - Bitmap mode all zeros discards the frame
// - Bitmap mode: each input marks one destination
// - Bitmap codes go through broadcast mechanism
// - Unmatched frames follow any non-noop external code
// - Unmatched noop, vlan mode: receive VLAN, or discard on port 00 with learning limit and no-learn
// - Unmatched noop, default: port 00 or discard
// - One VLAN group register per port
// - Broadcast limited to receiving port VLAN group
// - External engine supplies VLAN set in bitmap
// - Port_vlan_group_map at 00B8-00CB, two bytes
// - External code used only when enable set
// - Port no-learn bit disables internal matching
`timescale 1ns/1ps
`default_nettype none
module emf_forward_decision (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ext_match_mode_select,
  input wire logic ext_match_single_flag,
  input wire logic [9:0] ext_port_bitmap,
  input wire logic frame_start,
  input wire logic [3:0] rx_port,
  input wire logic da_matched,
  input wire logic [9:0] internal_dest_map,
  input wire logic is_bcast_mcast,
  input wire logic frame_queued,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output emf_pkg::emf_decision_t decision,
  output logic decision_valid,
  output logic decision_busy,
  output logic [9:0] learn_disable
);
  typedef enum logic [1:0] {
    EMF_IDLE = 2'b01,
    EMF_HOLD = 2'b10
  } emf_state_t;

  emf_state_t state_q;
  emf_pkg::emf_ext_code_t sync1_q;
  emf_pkg::emf_ext_code_t sync2_q;
  emf_pkg::emf_ext_code_t pins;
  emf_pkg::emf_decision_t decision_d;
  logic [7:0] feature_q;
  logic [7:0] port_ctrl_q [emf_pkg::NUM_PORTS];
  logic [9:0] vlan_q [emf_pkg::NUM_PORTS];
  logic [7:0] rdata_d;
  logic [9:0] rx_vlan;
  logic rx_no_learn;
  logic port00_no_learn;
  logic noop;
  logic ll;

  // Port index of a two-byte register pair; address bit 0 picks the byte
  function automatic logic [3:0] emf_pair_index(input logic [15:0] addr,
                                                input logic [15:0] base);
    logic [15:0] off;
    off = addr - base;
    return off[4:1];
  endfunction

  function automatic logic emf_in_range(input logic [15:0] addr, input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (addr >= lo) && (addr <= hi);
  endfunction

  function automatic logic [9:0] emf_port_bit(input logic [3:0] num);
    return emf_pkg::PORT00_MAP << num;
  endfunction

  // Code pins come from another chip; two flops before any use
  assign pins.ext_match_mode_select = ext_match_mode_select;
  assign pins.ext_match_single_flag = ext_match_single_flag;
  assign pins.ext_port_bitmap = ext_port_bitmap;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // no-learn bits held in port control
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      feature_q <= emf_pkg::FEATURE_CONFIG_RESET;
      for (int i = 0; i < emf_pkg::NUM_PORTS; i++) begin
        port_ctrl_q[i] <= '0;
        vlan_q[i] <= emf_pkg::VLAN_RESET;
      end
    end else if (reg_wr) begin
      if (reg_addr == emf_pkg::FEATURE_CONFIG_ADDR) begin
        feature_q <= reg_wdata;
      end
      if (emf_in_range(reg_addr, emf_pkg::PORT_CTRL_BASE, emf_pkg::PORT_CTRL_LAST) &&
          !reg_addr[0]) begin
        port_ctrl_q[emf_pair_index(reg_addr, emf_pkg::PORT_CTRL_BASE)] <= reg_wdata;
      end
      if (emf_in_range(reg_addr, emf_pkg::VLAN_BASE, emf_pkg::VLAN_LAST)) begin
        if (reg_addr[0]) begin
          vlan_q[emf_pair_index(reg_addr, emf_pkg::VLAN_BASE)][9:8] <=
            reg_wdata[emf_pkg::VLAN_HIGH_BITS-1:0];
        end else begin
          vlan_q[emf_pair_index(reg_addr, emf_pkg::VLAN_BASE)][7:0] <= reg_wdata;
        end
      end
    end
  end

  // Read mux; unmapped bytes and unused high bits read as zero
  always_comb begin
    rdata_d = '0;
    if (reg_addr == emf_pkg::FEATURE_CONFIG_ADDR) begin
      rdata_d = feature_q;
    end else if (emf_in_range(reg_addr, emf_pkg::PORT_CTRL_BASE,
                              emf_pkg::PORT_CTRL_LAST)) begin
      if (!reg_addr[0]) begin
        rdata_d = port_ctrl_q[emf_pair_index(reg_addr, emf_pkg::PORT_CTRL_BASE)];
      end
    end else if (emf_in_range(reg_addr, emf_pkg::VLAN_BASE, emf_pkg::VLAN_LAST)) begin
      if (reg_addr[0]) begin
        rdata_d = {6'h00, vlan_q[emf_pair_index(reg_addr, emf_pkg::VLAN_BASE)][9:8]};
      end else begin
        rdata_d = vlan_q[emf_pair_index(reg_addr, emf_pkg::VLAN_BASE)][7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // Guard rx_port beyond 9 so the arrays are never indexed out of range
  assign rx_vlan = (rx_port > emf_pkg::LAST_PORT_CODE) ? emf_pkg::EMPTY_MAP :
                   vlan_q[rx_port];
  assign rx_no_learn = (rx_port > emf_pkg::LAST_PORT_CODE) ? 1'b0 :
                       port_ctrl_q[rx_port][emf_pkg::NO_LEARN_BIT];
  assign port00_no_learn = port_ctrl_q[emf_pkg::PORT00_NUM][emf_pkg::NO_LEARN_BIT];
  assign ll = feature_q[emf_pkg::LEARNING_LIMIT_BIT];
  // mode and single flag high abstain
  assign noop = !feature_q[emf_pkg::EXT_MATCH_ENABLE_BIT] ||
                (sync2_q.ext_match_mode_select && sync2_q.ext_match_single_flag);

  // Decision for the frame starting now; external code outranks internal match
  always_comb begin
    decision_d = '0;
    if (!noop && sync2_q.ext_match_mode_select) begin
      if (sync2_q.ext_port_bitmap[3:0] <= emf_pkg::LAST_PORT_CODE) begin
        decision_d.map = emf_port_bit(sync2_q.ext_port_bitmap[3:0]);
      end else if (sync2_q.ext_port_bitmap[3:0] == emf_pkg::BCAST_CODE) begin
        decision_d.map = rx_vlan;
        decision_d.bcast = 1'b1;
      end else begin
        decision_d.discard = 1'b1;
      end
    end else if (!noop) begin
      if (sync2_q.ext_port_bitmap == emf_pkg::EMPTY_MAP) begin
        decision_d.discard = 1'b1;
      end else begin
        decision_d.map = sync2_q.ext_port_bitmap;
        decision_d.bcast = 1'b1;
      end
    end else if (da_matched && !rx_no_learn) begin
      if (is_bcast_mcast) begin
        decision_d.map = internal_dest_map & rx_vlan;
        decision_d.bcast = 1'b1;
      end else begin
        decision_d.map = internal_dest_map;
      end
    end else if (feature_q[emf_pkg::UNMATCHED_VLAN_BIT]) begin
      if (rx_port == emf_pkg::PORT00_NUM && ll && port00_no_learn) begin
        decision_d.discard = 1'b1;
      end else begin
        decision_d.map = rx_vlan;
        decision_d.bcast = 1'b1;
      end
    end else begin
      if (rx_port == emf_pkg::PORT00_NUM || (ll && !port00_no_learn)) begin
        decision_d.discard = 1'b1;
      end else begin
        decision_d.map = emf_pkg::PORT00_MAP;
      end
    end
    // A mask that leaves no port is a discard
    if (!decision_d.discard && decision_d.map == emf_pkg::EMPTY_MAP) begin
      decision_d.discard = 1'b1;
      decision_d.bcast = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= EMF_IDLE;
      decision <= '0;
      decision_valid <= 1'b0;
      decision_busy <= 1'b0;
    end else begin
      decision_valid <= 1'b0;
      case (state_q)
        EMF_IDLE: begin
          if (frame_start) begin
            decision <= decision_d;
            decision_valid <= 1'b1;
            decision_busy <= 1'b1;
            state_q <= EMF_HOLD;
          end
        end
        EMF_HOLD: begin
          if (frame_queued) begin
            decision_busy <= 1'b0;
            state_q <= EMF_IDLE;
          end
        end
        default: begin
          decision_busy <= 1'b0;
          state_q <= EMF_IDLE;
        end
      endcase
    end
  end

  // No-learn bits exported to the internal address registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      learn_disable <= '0;
    end else begin
      for (int i = 0; i < emf_pkg::NUM_PORTS; i++) begin
        learn_disable[i] <= port_ctrl_q[i][emf_pkg::NO_LEARN_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/emf_pkg.sv
// Constants and types shared by the external-match forwarding decision.
// Assumes a ten-port switch with a byte-wide internal register space.
package emf_pkg;
  localparam int unsigned NUM_PORTS = 10;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned ADDR_W = 16;

  // Register byte addresses
  localparam logic [15:0] PORT_CTRL_BASE = 16'h0080;
  localparam logic [15:0] PORT_CTRL_LAST = 16'h0093;
  localparam logic [15:0] VLAN_BASE = 16'h00b8;
  localparam logic [15:0] VLAN_LAST = 16'h00cb;
  localparam logic [15:0] FEATURE_CONFIG_ADDR = 16'h00d0;

  // Field positions
  localparam int unsigned NO_LEARN_BIT = 3;
  localparam int unsigned EXT_MATCH_ENABLE_BIT = 0;
  localparam int unsigned LEARNING_LIMIT_BIT = 1;
  localparam int unsigned UNMATCHED_VLAN_BIT = 2;
  localparam int unsigned VLAN_HIGH_BITS = 2;

  // Reset values
  localparam logic [7:0] FEATURE_CONFIG_RESET = 8'h00;
  localparam logic [9:0] VLAN_RESET = 10'h3ff;

  // Single-port codes
  localparam logic [3:0] LAST_PORT_CODE = 4'h9;
  localparam logic [3:0] BCAST_CODE = 4'hf;
  localparam logic [9:0] PORT00_MAP = 10'h001;
  localparam logic [9:0] EMPTY_MAP = 10'h000;
  localparam logic [3:0] PORT00_NUM = 4'h0;

  typedef struct packed {
    logic [NUM_PORTS-1:0] map;
    logic bcast;
    logic discard;
  } emf_decision_t;

  typedef struct packed {
    logic ext_match_mode_select;
    logic ext_match_single_flag;
    logic [NUM_PORTS-1:0] ext_port_bitmap;
  } emf_ext_code_t;
endpackage

// File: dv/emf_fd_sva.sv
// Port checker for the forwarding decision block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module emf_fd_sva (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic frame_start,
  input wire logic frame_queued,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire emf_pkg::emf_decision_t decision,
  input wire logic decision_valid,
  input wire logic decision_busy,
  input wire logic [9:0] learn_disable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Capture and its answer one cycle later
  sequence s_take; frame_start && !decision_busy; endsequence
  sequence s_answer; decision_valid && decision_busy; endsequence
  property p_take; s_take |=> s_answer; endproperty
  a_take: assert property (p_take) else $error("capture missed");
  property p_pulse; decision_valid |=> !decision_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_idle; !decision_busy && !frame_start |=> !decision_valid; endproperty
  a_idle: assert property (p_idle) else $error("valid without capture");
  property p_hold; decision_busy && !frame_queued |=> decision_busy && $stable(decision);
  endproperty
  a_hold: assert property (p_hold) else $error("decision moved");
  property p_free; decision_busy && frame_queued |=> !decision_busy; endproperty
  a_free: assert property (p_free) else $error("busy stuck");
  property p_map; decision_valid && !decision.discard |-> decision.map != 10'h000;
  endproperty
  a_map: assert property (p_map) else $error("empty map forwarded");
  property p_gap; reg_rd && reg_addr > 16'h00d0 |=> reg_rdata == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read nonzero");
  property p_keep; !reg_rd |=> $stable(reg_rdata); endproperty
  a_keep: assert property (p_keep) else $error("read data moved");
  property p_high;
    reg_rd && reg_addr inside {[16'h00b8:16'h00cb]} && reg_addr[0] |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_high: assert property (p_high) else $error("vlan high bits set");
  property p_nl; reg_wr && reg_addr == 16'h0080 |=> ##1 learn_disable[0] == $past(reg_wdata[3], 2);
  endproperty
  a_nl: assert property (p_nl) else $error("no-learn not applied");
endmodule
bind emf_forward_decision emf_fd_sva u_sva (.sys_clk, .reset_n, .frame_start, .frame_queued,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .decision, .decision_valid,
  .decision_busy, .learn_disable);
`default_nettype wire

// File: dv/emf_ext_engine.sv
// Model of the external lookup engine on the match code pins.
// Assumes the bench sets present and want just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module emf_ext_engine (
  input wire logic sys_clk,
  input wire logic present,
  input wire emf_pkg::emf_ext_code_t want,
  output emf_pkg::emf_ext_code_t pins
);
  // abstain, discard, vlan set, unicast code
  // Absent engine abstains; the ignored bits keep changing so nothing leans on them
  always @(posedge sys_clk) begin
    if (present) begin
      pins <= want;
    end else begin
      pins <= {2'b11, ~pins.ext_port_bitmap};
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Bench for the forwarding decision: register access and decisions.
// Assumes the package, the block and the engine model compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, reset_n, present, frame_start, frame_queued, da_matched, is_bcast_mcast;
  logic reg_wr, reg_rd, decision_valid, decision_busy, d;
  logic [2:0] f;
  logic [3:0] rx_port;
  logic [9:0] internal_dest_map, learn_disable, em;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  emf_pkg::emf_ext_code_t want, pins;
  emf_pkg::emf_decision_t decision;
  int failures, comparisons;
  emf_ext_engine eng (.sys_clk, .present, .want, .pins);
  emf_forward_decision dut (.sys_clk, .reset_n,
    .ext_match_mode_select(pins.ext_match_mode_select),
    .ext_match_single_flag(pins.ext_match_single_flag),
    .ext_port_bitmap(pins.ext_port_bitmap), .frame_start, .rx_port, .da_matched,
    .internal_dest_map, .is_bcast_mcast, .frame_queued, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .decision, .decision_valid, .decision_busy, .learn_disable);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Inputs move 1 ns after the edge so the block samples settled values
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    // One edge with the strobe low, so a following call never raises it in the same step
    tick;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    chk("rdata", 16'(reg_rdata), 16'(e));
    // Read data holds without a strobe; the idle edge keeps calls apart
    tick;
  endtask
  // Pins settle through the synchroniser first; start is held one extra
  // edge to show that a request while busy is dropped
  task automatic frame(input logic pr, input logic [11:0] code, input logic [3:0] rx,
      input logic hit, input logic bc, input logic [9:0] im, input logic [11:0] exp);
    present = pr;
    want = code;
    rx_port = rx;
    da_matched = hit;
    is_bcast_mcast = bc;
    internal_dest_map = im;
    repeat (4) tick;
    frame_start = 1'b1;
    tick;
    chk("valid", 16'(decision_valid), 16'h0001);
    if (exp[0]) chk("discard", 16'(decision.discard), 16'h0001);
    else chk("decision", 16'(decision), 16'(exp));
    tick;
    frame_start = 1'b0;
    chk("ignored", 16'(decision_valid), 16'h0000);
    frame_queued = 1'b1;
    tick;
    frame_queued = 1'b0;
    chk("busy", 16'(decision_busy), 16'h0000);
  endtask
  initial begin
    reset_n = 1'b0; present = 1'b1; want = 12'h000; frame_start = 1'b0; frame_queued = 1'b0;
    rx_port = 4'h0; da_matched = 1'b0; is_bcast_mcast = 1'b0; internal_dest_map = 10'h000;
    reg_addr = 16'h0000; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    rd(16'h00d0, 8'h00);
    rd(16'h00b8, 8'hff);
    rd(16'h00b9, 8'h03);
    wr(16'h00d1, 8'h5a);
    rd(16'h00d1, 8'h00);
    wr(16'h00bc, 8'h0f);
    wr(16'h00bd, 8'hff);
    rd(16'h00bd, 8'h03);
    rd(16'h00bc, 8'h0f);
    $display("test registers done");
    frame(1'b1, 12'h803, 4'h1, 1'b0, 1'b0, 10'h000, {10'h001, 2'b00});
    wr(16'h00d0, 8'h01);
    for (int c = 0; c < 16; c++) begin
      // Port 2 group map was written above as 0x30f
      em = (c < 10) ? 10'(1 << c) : ((c == 15) ? 10'h30f : 10'h000);
      frame(1'b1, {8'h80, 4'(c)}, 4'h2, 1'b0, 1'b0, 10'h000, {em, c == 15, em == 10'h000});
    end
    frame(1'b1, 12'h000, 4'h2, 1'b0, 1'b0, 10'h000, {10'h000, 2'b01});
    frame(1'b1, 12'h281, 4'h2, 1'b0, 1'b0, 10'h000, {10'h281, 2'b10});
    frame(1'b0, 12'h000, 4'h2, 1'b1, 1'b1, 10'h3f3, {10'h303, 2'b10});
    frame(1'b0, 12'h000, 4'h2, 1'b1, 1'b0, 10'h020, {10'h020, 2'b00});
    $display("test external codes done");
    // Third mode, learning limit and port 00 no-learn against both receive sides
    for (int k = 0; k < 16; k++) begin
      f = k[2:0];
      wr(16'h00d0, {5'h00, f[2:1], 1'b1});
      wr(16'h0080, {4'h0, f[0], 3'h0});
      tick;
      chk("nolearn", 16'(learn_disable[0]), 16'(f[0]));
      em = k[3] ? 10'h30f : 10'h3ff;
      d = !k[3] && f[1] && f[0];
      if (!f[2]) begin
        d = !k[3] || (f[1] && !f[0]);
        em = 10'h001;
      end
      frame(1'b0, 12'h000, k[3] ? 4'h2 : 4'h0, 1'b0, 1'b0, 10'h000, {em, f[2], d});
    end
    $display("test unmatched done");
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
